/* File: hdl/ccd_pkg.sv */
// Shared constants and types of the execution unit
package ccd_pkg;

   // Datapath widths
   localparam int DATA_W  = 8;
   localparam int FADDR_W = 7;
   localparam int IMM_W   = 11;
   localparam int PC_W    = 13;
   localparam int PAGE_W  = 5;
   localparam int AXI_AW  = 8;
   localparam int AXI_DW  = 32;

   // Page latch bits feeding upper PC bits on a call
   localparam int PAGE_HI = 4;
   localparam int PAGE_LO = 3;

   // Register byte offsets
   localparam logic [AXI_AW-1:0] ADDR_ACCUM  = 8'h00;
   localparam logic [AXI_AW-1:0] ADDR_PAGE   = 8'h04;
   localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h08;
   localparam logic [AXI_AW-1:0] ADDR_PC     = 8'h0C;
   localparam logic [AXI_AW-1:0] ADDR_STACK  = 8'h10;

   // Status register field positions
   localparam int ZERO_BIT = 0;
   localparam int PD_BIT   = 1;
   localparam int TO_BIT   = 2;

   // Values after reset
   localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
   localparam logic [PAGE_W-1:0] PAGE_RST  = 5'h00;
   localparam logic [PC_W-1:0]   PC_RST    = 13'h0000;
   localparam logic              ZERO_RST  = 1'h0;
   localparam logic              FLAG_RST  = 1'h1;

   // Constant operand values
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ONE  = 8'h01;
   localparam logic [PC_W-1:0]   PC_ONE    = 13'h0001;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Operation selected by the fetch path
   typedef enum logic [2:0] {
      OP_NONE,
      OP_WDT_CLR,
      OP_CALL,
      OP_FINV,
      OP_FZERO,
      OP_AZERO,
      OP_FDEC,
      OP_DECSKIP
   } ccd_op_t;

   // Execution sequence
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_SECOND
   } ccd_state_t;

endpackage

/* File: hdl/ccd_exec.sv */
// Execution unit for watchdog clear, call, complement, clear and decrement operations
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// RULE1 - Watchdog clear resets its counter and prescaler.
// RULE2 - Watchdog clear sets timeout and powerdown flags only.
// RULE3 - Call pushes program counter plus one onto the stack.
// RULE4 - Call loads immediate into PC[10:0], page bits 4:3 into PC[12:11].
// RULE5 - Call takes an 11-bit immediate, two cycles, no flags.
// RULE6 - Destination zero writes working register, one writes file.
// RULE7 - File address is seven bits; destination is one bit.
// RULE8 - Complement inverts the file value and updates zero flag.
// RULE9 - File clear writes zero and sets zero flag.
// RULE10 - Working register clear writes zero and sets zero flag.
// RULE11 - Decrement subtracts one and updates zero flag.
// RULE12 - Decrement-skip leaves flags; zero result discards next instruction.
// RULE13 - Zero flag set when complement or decrement result is zero.
module ccd_exec
   import ccd_pkg::*;
(
   input  wire logic               aclk,          // Instruction clock
   input  wire logic               aresetn,       // Sync reset, active low
   input  wire logic               ce,            // Low freezes all state
   // Instruction from the fetch path
   input  wire logic               instr_valid,   // Offered
   output logic                    instr_ready,   // Taken with valid
   input  wire ccd_op_t            instr_op,      // Operation
   input  wire logic [FADDR_W-1:0] instr_faddr,   // File address
   input  wire logic               instr_dest,    // Destination
   input  wire logic [IMM_W-1:0]   instr_imm,     // Call target
   // File register port
   output logic [FADDR_W-1:0]      file_addr,     // Address
   input  wire logic [DATA_W-1:0]  file_rd_data,  // Read data
   output logic                    file_we,       // Write pulse
   output logic [DATA_W-1:0]       file_wdata,    // Write data
   // Watchdog and stack
   output logic                    wdt_clear,     // Clears watchdog
   output logic                    stack_push,    // Push pulse
   output logic [PC_W-1:0]         stack_top,     // Return address
   output logic [PC_W-1:0]         pc,            // Program counter
   output logic                    zero_flag,     // Zero flag
   // AXI4-Lite slave
   input  wire logic [AXI_AW-1:0]  s_axi_awaddr,  // Write address
   input  wire logic               s_axi_awvalid, // Write address valid
   output logic                    s_axi_awready, // Write address ready
   input  wire logic [AXI_DW-1:0]  s_axi_wdata,   // Write data
   input  wire logic [3:0]         s_axi_wstrb,   // Write strobes
   input  wire logic               s_axi_wvalid,  // Write data valid
   output logic                    s_axi_wready,  // Write data ready
   output logic [1:0]              s_axi_bresp,   // Write response
   output logic                    s_axi_bvalid,  // Write response valid
   input  wire logic               s_axi_bready,  // Write response ready
   input  wire logic [AXI_AW-1:0]  s_axi_araddr,  // Read address
   input  wire logic               s_axi_arvalid, // Read address valid
   output logic                    s_axi_arready, // Read address ready
   output logic [AXI_DW-1:0]       s_axi_rdata,   // Read data
   output logic [1:0]              s_axi_rresp,   // Read response
   output logic                    s_axi_rvalid,  // Read data valid
   input  wire logic               s_axi_rready   // Read data ready
);

   // Decrement by one, wrapping at zero
   function automatic logic [DATA_W-1:0] ccd_dec8(input logic [DATA_W-1:0] v);
      ccd_dec8 = v - DATA_ONE;
   endfunction

   // Zero test
   function automatic logic ccd_is_zero(input logic [DATA_W-1:0] v);
      ccd_is_zero = (v == DATA_ZERO);
   endfunction

   // Word address match
   function automatic logic ccd_hit(input logic [AXI_AW-1:0] a, input logic [AXI_AW-1:0] o);
      ccd_hit = (a[AXI_AW-1:2] == o[AXI_AW-1:2]);
   endfunction

   ccd_state_t         state_reg;
   ccd_state_t         state_next;
   ccd_op_t            op_reg;
   logic               dest_reg;
   logic [IMM_W-1:0]   imm_reg;
   logic               instr_ready_reg;
   logic               skip_pending_reg;
   logic [FADDR_W-1:0] file_addr_reg;
   logic               file_we_reg;
   logic [DATA_W-1:0]  file_wdata_reg;
   logic               wdt_clear_reg;
   logic               stack_push_reg;
   logic [PC_W-1:0]    stack_top_reg;
   logic [PC_W-1:0]    pc_reg;
   logic [DATA_W-1:0]  accum_reg;
   logic [PAGE_W-1:0]  page_reg;
   logic               zero_reg;
   logic               to_n_reg;
   logic               pd_n_reg;
   logic               accept;
   logic               exec;
   logic [DATA_W-1:0]  result;
   logic               to_file;
   logic               to_accum;
   logic               zero_touch;
   logic               zero_val;
   // Bus slave state
   logic               awready_reg;
   logic               wready_reg;
   logic               aw_held_reg;
   logic               w_held_reg;
   logic [AXI_AW-1:0]  awaddr_reg;
   logic [DATA_W-1:0]  wdata_reg;
   logic               wlane_reg;
   logic               bvalid_reg;
   logic [1:0]         bresp_reg;
   logic               arready_reg;
   logic               rvalid_reg;
   logic [AXI_DW-1:0]  rdata_reg;
   logic [1:0]         rresp_reg;
   logic               bus_wr;
   logic               bus_wr_ok;
   logic [AXI_DW-1:0]  rd_word;
   logic               rd_ok;

   // Handshake qualifiers
   assign accept = instr_valid && instr_ready_reg;
   assign exec   = (state_reg == ST_EXEC);

   // Sequence with an extra slot for a call
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE:
         begin
            if (accept)
               state_next = ST_EXEC;
         end
         ST_EXEC:
         begin
            if (op_reg == OP_CALL)
               state_next = ST_SECOND;   // Call second slot [RULE5]
            else
               state_next = ST_IDLE;
         end
         ST_SECOND:
            state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
   end

   // State and ready, registered for clean levels
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg       <= ST_IDLE;
         instr_ready_reg <= 1'b0;
      end
      else if (ce)
      begin
         state_reg       <= state_next;
         instr_ready_reg <= (state_next == ST_IDLE);
      end
   end

   // Operands on accept; a pending skip makes a no-op
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         op_reg        <= OP_NONE;
         dest_reg      <= 1'b0;
         imm_reg       <= '0;
         file_addr_reg <= '0;
      end
      else if (ce && accept)
      begin
         op_reg        <= skip_pending_reg ? OP_NONE : instr_op;   // [RULE12]
         dest_reg      <= instr_dest;                              // [RULE7]
         imm_reg       <= instr_imm;                               // [RULE5]
         file_addr_reg <= instr_faddr;                             // [RULE7]
      end
   end

   // Result and destination per operation
   always_comb
   begin
      result     = DATA_ZERO;
      to_file    = 1'b0;
      to_accum   = 1'b0;
      zero_touch = 1'b0;
      zero_val   = 1'b0;
      unique case (op_reg)
         OP_NONE, OP_WDT_CLR, OP_CALL:
            result = DATA_ZERO;   // No data result, zero flag left alone [RULE5]
         OP_FINV:
         begin
            result     = ~file_rd_data;         // [RULE8]
            to_file    = dest_reg;              // [RULE6]
            to_accum   = !dest_reg;             // [RULE6]
            zero_touch = 1'b1;
            zero_val   = ccd_is_zero(result);   // [RULE13]
         end
         OP_FZERO:
         begin
            result     = DATA_ZERO;   // [RULE9]
            to_file    = 1'b1;
            zero_touch = 1'b1;
            zero_val   = 1'b1;        // [RULE9]
         end
         OP_AZERO:
         begin
            result     = DATA_ZERO;   // Operand fields are ignored [RULE10]
            to_accum   = 1'b1;
            zero_touch = 1'b1;
            zero_val   = 1'b1;        // [RULE10]
         end
         OP_FDEC:
         begin
            result     = ccd_dec8(file_rd_data);   // [RULE11]
            to_file    = dest_reg;                 // [RULE6]
            to_accum   = !dest_reg;                // [RULE6]
            zero_touch = 1'b1;
            zero_val   = ccd_is_zero(result);      // [RULE13]
         end
         OP_DECSKIP:
         begin
            result   = ccd_dec8(file_rd_data);   // No status change [RULE12]
            to_file  = dest_reg;                 // [RULE6]
            to_accum = !dest_reg;                // [RULE6]
         end
      endcase
   end

   // File write strobe and data
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         file_we_reg    <= 1'b0;
         file_wdata_reg <= DATA_ZERO;
      end
      else if (ce)
      begin
         file_we_reg <= exec && to_file;   // [RULE6]
         if (exec && to_file)
            file_wdata_reg <= result;
      end
   end

   // Skip: next accepted instruction is a no-op
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         skip_pending_reg <= 1'b0;
      else if (ce)
      begin
         if (exec && op_reg == OP_DECSKIP && ccd_is_zero(result))
            skip_pending_reg <= 1'b1;   // [RULE12]
         else if (accept)
            skip_pending_reg <= 1'b0;
      end
   end

   // Program counter and return address push
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pc_reg         <= PC_RST;
         stack_top_reg  <= PC_RST;
         stack_push_reg <= 1'b0;
      end
      else if (ce)
      begin
         stack_push_reg <= exec && (op_reg == OP_CALL);   // [RULE3]
         if (exec && op_reg == OP_CALL)
         begin
            stack_top_reg <= pc_reg + PC_ONE;                               // [RULE3]
            pc_reg        <= {page_reg[PAGE_HI:PAGE_LO], imm_reg};          // [RULE4]
         end
         else if (exec)
            pc_reg <= pc_reg + PC_ONE;
      end
   end

   // Watchdog clear strobe
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         wdt_clear_reg <= 1'b0;
      else if (ce)
         wdt_clear_reg <= exec && (op_reg == OP_WDT_CLR);   // [RULE1]
   end

   // Working register: execution wins over a bus write in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         accum_reg <= ACCUM_RST;
      else if (ce)
      begin
         if (exec && to_accum)
            accum_reg <= result;   // [RULE6]
         else if (bus_wr_ok && ccd_hit(awaddr_reg, ADDR_ACCUM))
            accum_reg <= wdata_reg;
      end
   end

   // Page latch, software only; steers call target
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         page_reg <= PAGE_RST;
      else if (ce && bus_wr_ok && ccd_hit(awaddr_reg, ADDR_PAGE))
         page_reg <= wdata_reg[PAGE_W-1:0];
   end

   // Status flags: hardware beats software
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         zero_reg <= ZERO_RST;
         to_n_reg <= FLAG_RST;
         pd_n_reg <= FLAG_RST;
      end
      else if (ce)
      begin
         if (exec && zero_touch)
            zero_reg <= zero_val;   // [RULE8] [RULE11]
         else if (bus_wr_ok && ccd_hit(awaddr_reg, ADDR_STATUS))
            zero_reg <= wdata_reg[ZERO_BIT];
         if (exec && op_reg == OP_WDT_CLR)
         begin
            to_n_reg <= 1'b1;   // [RULE2]
            pd_n_reg <= 1'b1;   // [RULE2]
         end
         else if (bus_wr_ok && ccd_hit(awaddr_reg, ADDR_STATUS))
         begin
            to_n_reg <= wdata_reg[TO_BIT];
            pd_n_reg <= wdata_reg[PD_BIT];
         end
      end
   end

   // Bus write: either order, one at a time
   assign bus_wr    = aw_held_reg && w_held_reg && !bvalid_reg;
   assign bus_wr_ok = bus_wr && wlane_reg;

   // Write address; ready pulses once after valid
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_reg <= 1'b0;
         aw_held_reg <= 1'b0;
         awaddr_reg  <= '0;
      end
      else if (ce)
      begin
         awready_reg <= s_axi_awvalid && !awready_reg && !aw_held_reg;
         if (s_axi_awvalid && awready_reg)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         else if (bus_wr)
            aw_held_reg <= 1'b0;
      end
   end

   // Write data channel; only byte lane 0 carries register bits
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wready_reg <= 1'b0;
         w_held_reg <= 1'b0;
         wdata_reg  <= DATA_ZERO;
         wlane_reg  <= 1'b0;
      end
      else if (ce)
      begin
         wready_reg <= s_axi_wvalid && !wready_reg && !w_held_reg;
         if (s_axi_wvalid && wready_reg)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata[DATA_W-1:0];
            wlane_reg  <= s_axi_wstrb[0];
         end
         else if (bus_wr)
            w_held_reg <= 1'b0;
      end
   end

   // Write response; unmapped gives SLVERR, read-only ignored
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
      end
      else if (ce)
      begin
         if (bus_wr)
         begin
            bvalid_reg <= 1'b1;
            if (ccd_hit(awaddr_reg, ADDR_ACCUM) || ccd_hit(awaddr_reg, ADDR_PAGE) ||
                ccd_hit(awaddr_reg, ADDR_STATUS) || ccd_hit(awaddr_reg, ADDR_PC) ||
                ccd_hit(awaddr_reg, ADDR_STACK))
               bresp_reg <= RESP_OKAY;
            else
               bresp_reg <= RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_reg <= 1'b0;
      end
   end

   // Read mux; unused upper bits read as zero
   always_comb
   begin
      rd_word = '0;
      rd_ok   = 1'b1;
      if (ccd_hit(s_axi_araddr, ADDR_ACCUM))
         rd_word[DATA_W-1:0] = accum_reg;
      else if (ccd_hit(s_axi_araddr, ADDR_PAGE))
         rd_word[PAGE_W-1:0] = page_reg;
      else if (ccd_hit(s_axi_araddr, ADDR_STATUS))
      begin
         rd_word[ZERO_BIT] = zero_reg;
         rd_word[PD_BIT]   = pd_n_reg;
         rd_word[TO_BIT]   = to_n_reg;
      end
      else if (ccd_hit(s_axi_araddr, ADDR_PC))
         rd_word[PC_W-1:0] = pc_reg;
      else if (ccd_hit(s_axi_araddr, ADDR_STACK))
         rd_word[PC_W-1:0] = stack_top_reg;
      else
         rd_ok = 1'b0;
   end

   // Read channel, data taken at address handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= '0;
         rresp_reg   <= RESP_OKAY;
      end
      else if (ce)
      begin
         arready_reg <= s_axi_arvalid && !arready_reg && !rvalid_reg;
         if (s_axi_arvalid && arready_reg)
         begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rready)
            rvalid_reg <= 1'b0;
      end
   end

   // Outputs straight from flip-flops
   assign instr_ready   = instr_ready_reg;
   assign file_addr     = file_addr_reg;
   assign file_we       = file_we_reg;
   assign file_wdata    = file_wdata_reg;
   assign wdt_clear     = wdt_clear_reg;
   assign stack_push    = stack_push_reg;
   assign stack_top     = stack_top_reg;
   assign pc            = pc_reg;
   assign zero_flag     = zero_reg;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

endmodule

`default_nettype wire

/* File: dv/ccd_file_model.sv */
// File register model standing beside the execution unit
`timescale 1ns/1ns
`default_nettype none
module ccd_file_model
   import ccd_pkg::*;
(
   input  wire logic               aclk,         // Clock
   input  wire logic [FADDR_W-1:0] file_addr,    // Address
   input  wire logic               file_we,      // Write strobe
   input  wire logic [DATA_W-1:0]  file_wdata,   // Write data
   output logic [DATA_W-1:0]       file_rd_data  // Read data
);
   logic [DATA_W-1:0] mem [128];
   // Read follows the address at once, so data is ready in the execute cycle
   assign file_rd_data = mem[file_addr];
   // Plain always so the bench may preset cells
   always @(posedge aclk)
      if (file_we === 1'b1) mem[file_addr] <= file_wdata;
endmodule
`default_nettype wire

/* File: dv/ccd_exec_sva.sv */
// Checker for the execution unit instruction port
`timescale 1ns/1ns
`default_nettype none
module ccd_exec_sva
   import ccd_pkg::*;
(
   input wire logic               aclk,          // Clock
   input wire logic               aresetn,       // Reset, active low
   input wire logic               ce,            // Clock enable
   input wire logic               instr_valid,   // Offered
   input wire logic               instr_ready,   // Taken
   input wire ccd_op_t            instr_op,      // Operation
   input wire logic [FADDR_W-1:0] instr_faddr,   // File address
   input wire logic               instr_dest,    // Destination
   input wire logic [IMM_W-1:0]   instr_imm,     // Immediate
   input wire logic [FADDR_W-1:0] file_addr,     // File address out
   input wire logic [DATA_W-1:0]  file_rd_data,  // File read data
   input wire logic               file_we,       // File write
   input wire logic [DATA_W-1:0]  file_wdata,    // File write data
   input wire logic               wdt_clear,     // Watchdog clear
   input wire logic               stack_push,    // Push
   input wire logic [PC_W-1:0]    stack_top,     // Return address
   input wire logic [PC_W-1:0]    pc,            // Program counter
   input wire logic               zero_flag      // Zero flag
);
   logic             ex, disc_r, pend, dest_r;
   logic [2:0]       op_r;
   logic [IMM_W-1:0] imm_r;
   wire              acc  = instr_valid && instr_ready && ce;
   wire              live = ex && !disc_r && ce;
   // Track each instruction to execute; zero skip discards next
   always_ff @(posedge aclk)
      if (!aresetn) {ex, disc_r, pend} <= 3'h0;
      else if (ce)
      begin
         ex <= acc;
         if (acc) {disc_r, op_r, dest_r, imm_r} <= {pend, instr_op, instr_dest, instr_imm};
         if (acc) pend <= 1'b0;
         else if (live && op_r == OP_DECSKIP && file_rd_data == DATA_ONE) pend <= 1'b1;
      end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_wdt; live && op_r == OP_WDT_CLR |=> wdt_clear; endproperty
   a_wdt: assert property (p_wdt)
      else $error("watchdog clear pulse missing");
   property p_call;
      live && op_r == OP_CALL |=> stack_push && stack_top == $past(pc) + PC_ONE
         && pc[10:0] == $past(imm_r);
   endproperty
   a_call: assert property (p_call)
      else $error("call push or target wrong");
   property p_call2;
      live && op_r == OP_CALL |=> !instr_ready && $stable(zero_flag) ##1 instr_ready;
   endproperty
   a_call2: assert property (p_call2)
      else $error("call length or flag wrong");
   property p_inv;
      live && op_r == OP_FINV |=> file_we == $past(dest_r) && zero_flag ==
         ($past(file_rd_data) == 8'hFF) && (!file_we || file_wdata == ~$past(file_rd_data));
   endproperty
   a_inv: assert property (p_inv)
      else $error("complement result wrong");
   property p_file_zero_op;
      live && op_r == OP_FZERO |=> file_we && file_wdata == DATA_ZERO && zero_flag;
   endproperty
   a_file_zero_op: assert property (p_file_zero_op)
      else $error("file clear wrong");
   property p_accum_zero_op; live && op_r == OP_AZERO |=> zero_flag && !file_we; endproperty
   a_accum_zero_op: assert property (p_accum_zero_op)
      else $error("working clear wrong");
   property p_dec;
      live && op_r == OP_FDEC |=> file_we == $past(dest_r) && zero_flag ==
         ($past(file_rd_data) == DATA_ONE) &&
         (!file_we || file_wdata == $past(file_rd_data) - DATA_ONE);
   endproperty
   a_dec: assert property (p_dec)
      else $error("decrement result wrong");
   property p_skip;
      live && op_r == OP_DECSKIP |=> $stable(zero_flag) && file_we == $past(dest_r);
   endproperty
   a_skip: assert property (p_skip)
      else $error("skip decrement wrong");
   property p_disc;
      ex && disc_r && ce |=> !file_we && !stack_push && !wdt_clear && pc == $past(pc) + PC_ONE;
   endproperty
   a_disc: assert property (p_disc)
      else $error("discarded instruction acted");
   property p_addr; acc |=> file_addr == $past(instr_faddr); endproperty
   a_addr: assert property (p_addr)
      else $error("file address not taken");
endmodule
bind ccd_exec ccd_exec_sva sva_u (.*);
`default_nettype wire

/* File: dv/ccd_exec_tb.sv */
// Testbench for the execution unit
`timescale 1ns/1ns
`default_nettype none
module ccd_exec_tb;
   import ccd_pkg::*;
   logic aclk = 0, aresetn = 0, ce = 1, instr_valid = 0, instr_dest = 0;
   logic instr_ready, file_we, wdt_clear, stack_push, zero_flag;
   ccd_op_t instr_op = OP_NONE;
   logic [FADDR_W-1:0] instr_faddr = '0, file_addr;
   logic [IMM_W-1:0] instr_imm = '0;
   logic [DATA_W-1:0] file_rd_data, file_wdata;
   logic [PC_W-1:0] stack_top, pc, exp_pc = '0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, z_exp = 0, skip = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [4:0] page_m = '0;
   int n_mismatch = 0, comparisons = 0;
   ccd_op_t ops [3] = '{OP_FINV, OP_FDEC, OP_DECSKIP};
   logic [7:0] vals [3] = '{8'h01, 8'hFF, 8'h5A};
   ccd_exec dut_u (.*);
   ccd_file_model fm_u (.*);
   always #10 aclk = ~aclk;
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Write: address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hF};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      s_axi_bready <= 1'b0;
      chk("bresp", RESP_OKAY, s_axi_bresp);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n = 0;
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask
   // One instruction on preset cell v; pulses checked while they stand
   task automatic exec(input ccd_op_t op, input logic [6:0] fa, input logic d,
                       input logic [10:0] k, input logic [7:0] v);
      logic disc, we, al;
      logic [7:0] r;
      logic [12:0] st;
      disc = skip;
      r = (op == OP_FINV) ? ~v : (op == OP_FZERO) ? 8'h00 : v - 8'h01;
      al = !disc && op inside {OP_FINV, OP_FDEC, OP_DECSKIP};
      we = !disc && (op == OP_FZERO || (d && al));
      fm_u.mem[fa] = v;
      @(posedge aclk);
      {instr_valid, instr_op, instr_faddr, instr_dest, instr_imm} <= {1'b1, op, fa, d, k};
      do @(posedge aclk); while (instr_ready !== 1'b1);
      instr_valid <= 1'b0;
      @(posedge aclk);
      #1;
      st = exp_pc + 13'h0001;
      exp_pc = (!disc && op == OP_CALL) ? {page_m[4:3], k} : st;
      if (!disc && op inside {OP_FINV, OP_FDEC}) z_exp = (r == 8'h00);
      if (!disc && op inside {OP_FZERO, OP_AZERO}) z_exp = 1'b1;
      chk("file_we", we, file_we);
      if (we) chk("file_wdata", r, file_wdata);
      chk("file_addr", fa, file_addr);
      chk("zero_flag", z_exp, zero_flag);
      chk("pc", exp_pc, pc);
      chk("wdt_clear", !disc && op == OP_WDT_CLR, wdt_clear);
      chk("stack_push", !disc && op == OP_CALL, stack_push);
      if (!disc && op == OP_CALL) chk("stack_top", st, stack_top);
      skip = !disc && op == OP_DECSKIP && r == 8'h00;
      if (al && !d) rd_chk(ADDR_ACCUM, r, RESP_OKAY);
      if (!disc && op == OP_AZERO) rd_chk(ADDR_ACCUM, 0, RESP_OKAY);
   endtask
   // Watchdog: tests take about two hundred cycles, limit is 10000
   initial
   begin
      #200000;
      n_mismatch++;
      conclude();
   end
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(ADDR_STATUS, 32'h6, RESP_OKAY);
      rd_chk(8'h14, 0, RESP_SLVERR);
      wr(ADDR_PC, 32'h1234);
      rd_chk(ADDR_PC, 0, RESP_OKAY);
      $display("test reset done");
      wr(ADDR_STATUS, 32'h1);
      z_exp = 1'b1;
      exec(OP_WDT_CLR, 0, 0, 0, 0);
      rd_chk(ADDR_STATUS, 32'h7, RESP_OKAY);
      $display("test watchdog done");
      wr(ADDR_PAGE, 32'h1F);
      page_m = 5'h1F;
      exec(OP_CALL, 0, 0, 11'h7FF, 0);
      wr(ADDR_PAGE, 32'h0F);
      page_m = 5'h0F;
      exec(OP_CALL, 0, 0, 11'h000, 0);
      $display("test call done");
      // Complement and both decrements, both destinations, edge addresses, zero results
      foreach (ops[i]) foreach (vals[j]) for (int d = 0; d < 2; d++)
      begin
         exec(ops[i], d ? 7'h7F : 7'h00, d[0], 0, vals[j]);
         if (skip) exec(OP_FZERO, 7'h40, 1'b1, 0, 8'h33);
      end
      $display("test arithmetic done");
      wr(ADDR_STATUS, 0);
      z_exp = 1'b0;
      exec(OP_FZERO, 7'h7F, 0, 0, 8'hAA);
      wr(ADDR_STATUS, 0);
      wr(ADDR_ACCUM, 32'h55);
      z_exp = 1'b0;
      exec(OP_AZERO, 0, 0, 0, 8'h55);
      $display("test clears done");
      conclude();
   end
endmodule
`default_nettype wire
